//--- core/ipcb_defs.svh
// Register offsets, field positions, reset values and write masks of the priority bank.
`ifndef IPCB_DEFS_SVH
`define IPCB_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IPCB_IDX_PRIO0        6'h00
`define IPCB_IDX_PRIO1        6'h01
`define IPCB_IDX_PRIO2        6'h02
`define IPCB_IDX_PRIO3        6'h03
`define IPCB_IDX_PRIO4        6'h04
`define IPCB_IDX_VBASE        6'h05
`define IPCB_IDX_FMATCH0      6'h06
`define IPCB_IDX_FVLOW0       6'h07
`define IPCB_IDX_FVHIGH0      6'h08
`define IPCB_IDX_FMATCH1      6'h09
`define IPCB_IDX_FVLOW1       6'h0a
`define IPCB_IDX_FVHIGH1      6'h0b
`define IPCB_IDX_PEND0        6'h0c
`define IPCB_IDX_PEND1        6'h0d
`define IPCB_IDX_PEND2        6'h0e
`define IPCB_IDX_INTERRUPT_CONTROL        6'h12
`define IPCB_IDX_EVSTAT       6'h13
`define IPCB_IDX_EVMASK       6'h14
`define IPCB_NUM_RW           12

// ----------------------------------------------------------------------------
// Writable bits; reserved bits read zero and ignore writes
// ----------------------------------------------------------------------------
`define IPCB_WMASK_PRIO0      16'hc3ff
`define IPCB_WMASK_PRIO1      16'hfcff
`define IPCB_WMASK_PRIO2      16'hf3ff
`define IPCB_WMASK_PRIO3      16'hfff0
`define IPCB_WMASK_PRIO4      16'h00ff
`define IPCB_WMASK_FULL       16'hffff
`define IPCB_RESET_VAL        16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IPCB_FLD_DISABLED     2'b00
`define IPCB_NUM_DEBUG        5
`define IPCB_INTERRUPT_CONTROL_WAKE_EN    5
`define IPCB_EV_REQ           0
`define IPCB_EV_FAST          1
`define IPCB_EV_WAKE          2
`define IPCB_EV_BITS          3

`endif

//--- core/ipcb_pkg.sv
// Types shared by the priority bank modules.
package ipcb_pkg;
  typedef logic [1:0] ipcb_level_t;
  typedef logic [6:0] ipcb_vec_t;
  typedef enum logic [0:0] {
    IPCB_WR_IDLE = 1'b0,
    IPCB_WR_RESP = 1'b1
  } ipcb_wr_e;
endpackage : ipcb_pkg

//--- core/ipcb_arb_if.sv
// Interface between the register bank and the arbitration core.
`timescale 1ns/1ns
interface ipcb_arb_if #(parameter int NSRC = 30);
  logic [NSRC-1:0]   req;
  logic [2*NSRC-1:0] fields;
  logic [15:0]       vbase;
  logic [15:0]       fmatch0;
  logic [15:0]       fmatch1;
  logic [15:0]       fvlow0;
  logic [15:0]       fvhigh0;
  logic [15:0]       fvlow1;
  logic [15:0]       fvhigh1;
  logic [NSRC-1:0]   enabled;
  logic              hit;
  logic [1:0]        level;
  logic [6:0]        vec_num;
  logic [22:0]       vec_addr;
  logic              fast;
  modport bank (output req, fields, vbase, fmatch0, fmatch1, fvlow0, fvhigh0, fvlow1,
                fvhigh1, input enabled, hit, level, vec_num, vec_addr, fast);
  modport arb  (input req, fields, vbase, fmatch0, fmatch1, fvlow0, fvhigh0, fvlow1,
                fvhigh1, output enabled, hit, level, vec_num, vec_addr, fast);
endinterface : ipcb_arb_if

//--- core/ipcb_arbiter.sv
// Combinational level decode, priority encode and vector selection.
`timescale 1ns/1ns
`include "ipcb_defs.svh"
module ipcb_arbiter import ipcb_pkg::*; #(
  parameter int        NSRC    = 30,
  parameter logic [6:0] VEC_OFS = 7'h00
) (
  ipcb_arb_if.arb a
);

  // Returns {enabled, level}; debug fields sit one level higher than peripheral ones.
  function automatic logic [2:0] decode_field(input logic [1:0] fld, input logic dbg);
    logic [1:0] lvl;
    lvl = fld - 2'd1;
    if (dbg) begin
      lvl = fld;
    end
    decode_field = {fld != `IPCB_FLD_DISABLED, lvl};
  endfunction : decode_field

  logic [1:0]  best_lvl;
  logic        best_hit;
  logic [6:0]  best_src;
  logic [2:0]  dec;
  logic        match0;
  logic        match1;
  logic [6:0]  win_vec;

  always_comb begin
    best_lvl  = 2'd0;
    best_hit  = 1'b0;
    best_src  = 7'd0;
    dec       = 3'd0;
    a.enabled = '0;
    // Walking downward with >= lets the lower source number win a tie.
    for (int i = NSRC - 1; i >= 0; i--) begin
      dec = decode_field(a.fields[2*i +: 2], i < `IPCB_NUM_DEBUG);
      a.enabled[i] = dec[2];
      if (dec[2] && a.req[i] && (!best_hit || dec[1:0] >= best_lvl)) begin
        best_lvl = dec[1:0];
        best_hit = 1'b1;
        best_src = 7'(i);
      end
    end
  end

  assign win_vec   = 7'(best_src + VEC_OFS);
  assign match0    = win_vec == a.fmatch0[6:0];
  assign match1    = win_vec == a.fmatch1[6:0];
  assign a.hit     = best_hit;
  assign a.level   = best_lvl;
  assign a.vec_num = win_vec;
  assign a.fast    = best_hit && best_lvl == 2'd2 && (match0 || match1);
  assign a.vec_addr = !a.fast ? {a.vbase, win_vec} :
                      match0  ? {a.fvhigh0[6:0], a.fvlow0} :
                                {a.fvhigh1[6:0], a.fvlow1};

endmodule : ipcb_arbiter

//--- core/ipcb_bank.sv
// Interrupt priority configuration bank with AXI4-Lite register access.
// Function
// - Peripheral field: 0 off, else level code-1.
// - Debug field: 0 off, else level equals code.
// - All priority fields reset to disabled.
// - Reserved priority bits read zero, ignore writes.
// - First register: low-voltage plus five debug fields.
// - Second register: ports, flash, clock-synth fields.
// - Low-voltage field uses peripheral levels, reset disabled.
// - Priority registers 0-4, vector base at 5.
// - Fast channels at offsets 6-8 and 9-B.
// - Pending words C-E, control at 12.
// - Same level: lowest source number wins.
// - Vector address is base concatenated with vector.
// - Level-2 fast match uses channel vector address.
// - Wake only for sources enabled before sleep.
`timescale 1ns/1ns
`include "ipcb_defs.svh"
module ipcb_bank import ipcb_pkg::*; #(
  parameter int         NSRC    = 30,
  parameter logic [6:0] VEC_OFS = 7'h00
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [NSRC-1:0] irq_req,
  input  wire logic        low_power_mode,
  output logic             core_irq_valid,
  output logic [1:0]       core_irq_level,
  output logic [6:0]       core_irq_vector,
  output logic [22:0]      core_vector_addr,
  output logic             core_irq_fast,
  output logic             clock_restart_req,
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] wmask(input logic [5:0] idx);
    case (idx)
      `IPCB_IDX_PRIO0: wmask = `IPCB_WMASK_PRIO0;
      `IPCB_IDX_PRIO1: wmask = `IPCB_WMASK_PRIO1;
      `IPCB_IDX_PRIO2: wmask = `IPCB_WMASK_PRIO2;
      `IPCB_IDX_PRIO3: wmask = `IPCB_WMASK_PRIO3;
      `IPCB_IDX_PRIO4: wmask = `IPCB_WMASK_PRIO4;
      default:         wmask = `IPCB_WMASK_FULL;
    endcase
  endfunction : wmask

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ipcb_wr_e                  wr_state_q;
  logic [15:0]               regs_q [0:`IPCB_NUM_RW-1];
  logic [5:0]                aw_idx_q;
  logic                      aw_held_q;
  logic [15:0]               w_data_q;
  logic [1:0]                w_strb_q;
  logic                      w_held_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic                      rvalid_q;
  logic [31:0]               rdata_q;
  logic [1:0]                rresp_q;
  logic [15:0]               interrupt_control_q;
  logic [`IPCB_EV_BITS-1:0]  evstat_q;
  logic [`IPCB_EV_BITS-1:0]  evmask_q;
  logic [NSRC-1:0]           snap_en_q;
  logic                      lp_prev_q;
  logic                      hit_prev_q;
  logic                      fast_prev_q;
  logic                      wake_prev_q;
  logic                      valid_q;
  logic [1:0]                level_q;
  logic [6:0]                vector_q;
  logic [22:0]               vaddr_q;
  logic                      fast_q;
  logic                      wake_q;

  ipcb_arb_if #(.NSRC(NSRC)) arb_if ();

  ipcb_arbiter #(
    .NSRC    (NSRC),
    .VEC_OFS (VEC_OFS)
  ) u_arb (
    .a (arb_if.arb)
  );

  // --------------------------------------------------------------------------
  // Field gathering: source 0..4 debug, 5 low-voltage, then ports, flash, etc.
  // --------------------------------------------------------------------------
  assign arb_if.fields  = {regs_q[4][7:0], regs_q[3][15:4], regs_q[2][15:12],
                           regs_q[2][9:0], regs_q[1][15:10], regs_q[1][7:0],
                           regs_q[0][15:14], regs_q[0][9:0]};
  assign arb_if.req     = irq_req;
  assign arb_if.vbase   = regs_q[5];
  assign arb_if.fmatch0 = regs_q[6];
  assign arb_if.fvlow0  = regs_q[7];
  assign arb_if.fvhigh0 = regs_q[8];
  assign arb_if.fmatch1 = regs_q[9];
  assign arb_if.fvlow1  = regs_q[10];
  assign arb_if.fvhigh1 = regs_q[11];

  // --------------------------------------------------------------------------
  // Write channel decode
  // --------------------------------------------------------------------------
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire        aw_have  = aw_held_q || aw_take;
  wire        w_have   = w_held_q || w_take;
  wire [5:0]  wr_idx   = aw_held_q ? aw_idx_q : s_axi_awaddr[7:2];
  wire [15:0] wr_data  = w_held_q ? w_data_q : s_axi_wdata[15:0];
  wire [1:0]  wr_strb  = w_held_q ? w_strb_q : s_axi_wstrb[1:0];
  wire        wr_go    = wr_state_q == IPCB_WR_IDLE && aw_have && w_have;
  wire        wr_rw    = wr_idx < 6'(`IPCB_NUM_RW);
  wire        wr_interrupt_control = wr_idx == `IPCB_IDX_INTERRUPT_CONTROL;
  wire        wr_stat  = wr_idx == `IPCB_IDX_EVSTAT;
  wire        wr_mask  = wr_idx == `IPCB_IDX_EVMASK;
  wire        wr_pend  = wr_idx >= `IPCB_IDX_PEND0 && wr_idx <= `IPCB_IDX_PEND2;
  wire        wr_ok    = wr_rw || wr_interrupt_control || wr_stat || wr_mask || wr_pend;
  wire [15:0] wr_val   = merge(16'h0000, wr_data, wr_strb);

  assign s_axi_awready = wr_state_q == IPCB_WR_IDLE && !aw_held_q;
  assign s_axi_wready  = wr_state_q == IPCB_WR_IDLE && !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= IPCB_WR_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      aw_idx_q   <= 6'h00;
      w_data_q   <= 16'h0000;
      w_strb_q   <= 2'b00;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'b00;
    end else begin
      case (wr_state_q)
        IPCB_WR_IDLE: begin
          if (wr_go) begin
            wr_state_q <= IPCB_WR_RESP;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            bvalid_q   <= 1'b1;
            bresp_q    <= wr_ok ? 2'b00 : 2'b10;
          end else begin
            if (aw_take) begin
              aw_held_q <= 1'b1;
              aw_idx_q  <= s_axi_awaddr[7:2];
            end
            if (w_take) begin
              w_held_q <= 1'b1;
              w_data_q <= s_axi_wdata[15:0];
              w_strb_q <= s_axi_wstrb[1:0];
            end
          end
        end
        IPCB_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= IPCB_WR_IDLE;
            bvalid_q   <= 1'b0;
          end
        end
        default: begin
          wr_state_q <= IPCB_WR_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `IPCB_NUM_RW; i++) begin
        regs_q[i] <= `IPCB_RESET_VAL;
      end
      interrupt_control_q  <= `IPCB_RESET_VAL;
      evmask_q <= '0;
    end else if (wr_go) begin
      if (wr_rw) begin
        regs_q[wr_idx[3:0]] <= merge(regs_q[wr_idx[3:0]], wr_data, wr_strb)
                               & wmask(wr_idx);
      end
      if (wr_interrupt_control) begin
        interrupt_control_q[`IPCB_INTERRUPT_CONTROL_WAKE_EN] <= wr_strb[0] ? wr_data[`IPCB_INTERRUPT_CONTROL_WAKE_EN]
                                                   : interrupt_control_q[`IPCB_INTERRUPT_CONTROL_WAKE_EN];
      end
      if (wr_mask) begin
        evmask_q <= wr_val[`IPCB_EV_BITS-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  wire [5:0]  rd_idx  = s_axi_araddr[7:2];
  wire [47:0] pend    = 48'(irq_req & arb_if.enabled);
  wire [15:0] interrupt_control_rd = {10'h000, interrupt_control_q[`IPCB_INTERRUPT_CONTROL_WAKE_EN], low_power_mode,
                          clock_restart_req, core_irq_fast, core_irq_valid, 1'b0};
  wire        rd_rw   = rd_idx < 6'(`IPCB_NUM_RW);
  wire        rd_pend = rd_idx >= `IPCB_IDX_PEND0 && rd_idx <= `IPCB_IDX_PEND2;
  wire [1:0]  rd_pw   = 2'(rd_idx - `IPCB_IDX_PEND0);
  wire [15:0] rd_val  = rd_rw ? regs_q[rd_idx[3:0]] :
                        rd_pend ? pend[16*rd_pw +: 16] :
                        rd_idx == `IPCB_IDX_INTERRUPT_CONTROL  ? interrupt_control_rd :
                        rd_idx == `IPCB_IDX_EVSTAT ? 16'(evstat_q) :
                        rd_idx == `IPCB_IDX_EVMASK ? 16'(evmask_q) : 16'h0000;
  wire        rd_ok   = rd_rw || rd_pend || rd_idx == `IPCB_IDX_INTERRUPT_CONTROL ||
                        rd_idx == `IPCB_IDX_EVSTAT || rd_idx == `IPCB_IDX_EVMASK;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rd_val};
      rresp_q  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Core-facing outputs and low-power wake
  // --------------------------------------------------------------------------
  // The enable snapshot is taken on entry so that a source enabled while asleep
  // cannot restart the clocks.
  wire lp_enter = low_power_mode && !lp_prev_q;
  wire wake_d   = low_power_mode && interrupt_control_q[`IPCB_INTERRUPT_CONTROL_WAKE_EN] &&
                  |(irq_req & (lp_enter ? arb_if.enabled : snap_en_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      valid_q     <= 1'b0;
      level_q     <= 2'b00;
      vector_q    <= 7'h00;
      vaddr_q     <= 23'h000000;
      fast_q      <= 1'b0;
      wake_q      <= 1'b0;
      lp_prev_q   <= 1'b0;
      snap_en_q   <= '0;
    end else begin
      valid_q     <= arb_if.hit;
      level_q     <= arb_if.level;
      vector_q    <= arb_if.vec_num;
      vaddr_q     <= arb_if.vec_addr;
      fast_q      <= arb_if.fast;
      wake_q      <= wake_d;
      lp_prev_q   <= low_power_mode;
      if (lp_enter) begin
        snap_en_q <= arb_if.enabled;
      end
    end
  end

  assign core_irq_valid    = valid_q;
  assign core_irq_level    = level_q;
  assign core_irq_vector   = vector_q;
  assign core_vector_addr  = vaddr_q;
  assign core_irq_fast     = fast_q;
  assign clock_restart_req = wake_q;

  // --------------------------------------------------------------------------
  // Event status, mask and interrupt line
  // --------------------------------------------------------------------------
  wire [`IPCB_EV_BITS-1:0] ev_set = {wake_q && !wake_prev_q, fast_q && !fast_prev_q,
                                     valid_q && !hit_prev_q};
  wire [`IPCB_EV_BITS-1:0] ev_clr = (wr_go && wr_stat) ? wr_val[`IPCB_EV_BITS-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evstat_q    <= '0;
      hit_prev_q  <= 1'b0;
      fast_prev_q <= 1'b0;
      wake_prev_q <= 1'b0;
    end else begin
      // A new event in the clearing cycle survives the clear.
      evstat_q    <= (evstat_q & ~ev_clr) | ev_set;
      hit_prev_q  <= valid_q;
      fast_prev_q <= fast_q;
      wake_prev_q <= wake_q;
    end
  end

  assign irq = |(evstat_q & evmask_q);

endmodule : ipcb_bank

//--- dv/ipcb_bank_properties.sv
// Concurrent checks on the ports of the priority bank.
`timescale 1ns/1ns
module ipcb_bank_properties import ipcb_pkg::*; #(
  parameter int NSRC = 30
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [NSRC-1:0] irq_req,
  input wire logic            low_power_mode,
  input wire logic            core_irq_valid,
  input wire logic [1:0]      core_irq_level,
  input wire logic [6:0]      core_irq_vector,
  input wire logic [22:0]     core_vector_addr,
  input wire logic            core_irq_fast,
  input wire logic            clock_restart_req,
  input wire logic            irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The reset check must run while reset is low, so it overrides the default.
  property p_reset_quiet;
    disable iff (1'b0) !aresetn |=> !core_irq_valid && !irq && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_no_req;
    irq_req == '0 |=> !core_irq_valid;
  endproperty
  property p_fast_level;
    core_irq_fast |-> core_irq_valid && core_irq_level == 2'h2;
  endproperty
  property p_norm_addr;
    core_irq_valid && !core_irq_fast |-> core_vector_addr[6:0] == core_irq_vector;
  endproperty
  property p_wake_lpm;
    clock_restart_req |-> $past(low_power_mode);
  endproperty
  property p_rdata_hi;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_write_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  a_no_req: assert property (p_no_req) else $error("valid without request");
  a_fast_level: assert property (p_fast_level) else $error("fast not at level 2");
  a_norm_addr: assert property (p_norm_addr) else $error("vector address wrong");
  a_wake_lpm: assert property (p_wake_lpm) else $error("wake outside low power");
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  a_write_lat: assert property (p_write_lat) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  c_fast: cover property (core_irq_fast);
  c_wake: cover property (clock_restart_req);
  c_irq: cover property (irq);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : ipcb_bank_properties

bind ipcb_bank ipcb_bank_properties #(.NSRC(NSRC)) ipcb_bank_properties_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .irq_req, .low_power_mode, .core_irq_valid, .core_irq_level, .core_irq_vector,
  .core_vector_addr, .core_irq_fast, .clock_restart_req, .irq);

//--- dv/ipcb_core_model.sv
// Processor core stand-in that latches the vector address it would fetch.
`timescale 1ns/1ns
module ipcb_core_model import ipcb_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        core_irq_valid,
  input  wire logic [22:0] core_vector_addr,
  output logic [22:0]      taken_addr_q
);
  // The core keeps the last fetched address, so a stale vector stays visible.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_addr_q <= 23'h000000;
    end else if (core_irq_valid) begin
      taken_addr_q <= core_vector_addr;
    end
  end
endmodule : ipcb_core_model

//--- dv/ipcb_bank_bench.sv
// Self-checking bench for the priority bank.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module ipcb_bank_bench import ipcb_pkg::*; ;
  localparam logic [6:0]  VOFS = 7'h10;
  localparam logic [15:0] VB = 16'h1234;
  localparam logic [15:0] WM [5] = '{16'hc3ff, 16'hfcff, 16'hf3ff, 16'hfff0, 16'h00ff};
  logic aclk = 1'b0, aresetn = 1'b0, low_power_mode = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [29:0] irq_req = 30'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_irq_level;
  logic [31:0] s_axi_rdata;
  logic [6:0] core_irq_vector;
  logic [22:0] core_vector_addr, taken_addr_q;
  logic core_irq_valid, core_irq_fast, clock_restart_req, irq;
  int miscompares = 0;
  int compares = 0;

  always #5 aclk = ~aclk;
  ipcb_bank #(.NSRC(30), .VEC_OFS(VOFS)) ipcb_bank_i (.*);
  ipcb_core_model ipcb_core_model_i (.aclk, .aresetn, .core_irq_valid, .core_vector_addr,
    .taken_addr_q);

  // --------------------------------------------------------------------------
  // Bus and support tasks
  // --------------------------------------------------------------------------
  task automatic final_report;
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic hang;
    miscompares++;
    final_report();
  endtask : hang

  // Handshakes are judged at the falling edge, where nothing is switching.
  task automatic wr(input logic [5:0] ix, input logic [15:0] d, input logic [1:0] er);
    logic a, w, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 60 && !done; n++) begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      if (done) `CHK("bresp", er, s_axi_bresp)
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!done) hang();
  endtask : wr

  task automatic rd(input logic [5:0] ix, input logic [15:0] d, input logic [1:0] er);
    logic a, done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 60 && !done; n++) begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      if (done) `CHK("rdata", {16'h0000, d, er}, {s_axi_rdata, s_axi_rresp})
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!done) hang();
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic core(input logic v, input logic [1:0] l, input logic [6:0] s);
    settle();
    `CHK("valid", v, core_irq_valid)
    if (v) `CHK("core", {l, s + VOFS, VB, s + VOFS},
      {core_irq_level, core_irq_vector, core_vector_addr})
  endtask : core

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_map;
    logic [15:0] m;
    for (int i = 0; i < 12; i++) begin
      m = (i < 5) ? WM[i] : 16'hffff;
      rd(i[5:0], 16'h0000, 2'b00);
      wr(i[5:0], 16'hffff, 2'b00);
      rd(i[5:0], m, 2'b00);
      wr(i[5:0], 16'h0000, 2'b00);
    end
    wr(6'h0c, 16'hffff, 2'b00);
    rd(6'h0c, 16'h0000, 2'b00);
    rd(6'h12, 16'h0000, 2'b00);
    wr(6'h0f, 16'hffff, 2'b10);
    rd(6'h0f, 16'h0000, 2'b10);
    wr(6'h05, VB, 2'b00);
  endtask : t_map

  task automatic t_decode;
    for (int c = 1; c < 4; c++) begin
      wr(6'h00, 16'(c), 2'b00);
      irq_req <= 30'h1;
      core(1'b1, 2'(c), 7'h00);
      wr(6'h00, 16'(c) << 14, 2'b00);
      irq_req <= 30'h20;
      core(1'b1, 2'(c - 1), 7'h05);
      wr(6'h00, 16'h0000, 2'b00);
      wr(6'h01, 16'(c), 2'b00);
      irq_req <= 30'h40;
      core(1'b1, 2'(c - 1), 7'h06);
      wr(6'h01, 16'h0000, 2'b00);
    end
  endtask : t_decode

  task automatic t_tie;
    wr(6'h01, 16'h0005, 2'b00);
    irq_req <= 30'hc0;
    core(1'b1, 2'h0, 7'h06);
    rd(6'h0c, 16'h00c0, 2'b00);
    wr(6'h01, 16'h0009, 2'b00);
    core(1'b1, 2'h1, 7'h07);
    @(posedge aclk);
    irq_req <= 30'h1000;
    core(1'b0, 2'h0, 7'h00);
  endtask : t_tie

  task automatic t_fast;
    wr(6'h01, 16'h000c, 2'b00);
    wr(6'h09, {9'h000, 7'h07 + VOFS}, 2'b00);
    wr(6'h0a, 16'habcd, 2'b00);
    wr(6'h0b, 16'h0055, 2'b00);
    irq_req <= 30'h80;
    settle();
    `CHK("fast", {1'b1, 7'h55, 16'habcd}, {core_irq_fast, core_vector_addr})
    `CHK("taken", {7'h55, 16'habcd}, taken_addr_q)
    wr(6'h06, {9'h000, 7'h07 + VOFS}, 2'b00);
    settle();
    `CHK("fast0", {1'b1, 23'h000000}, {core_irq_fast, core_vector_addr})
    wr(6'h01, 16'h0008, 2'b00);
    core(1'b1, 2'h1, 7'h07);
    `CHK("fast", 1'b0, core_irq_fast)
  endtask : t_fast

  task automatic t_events;
    @(posedge aclk);
    irq_req <= 30'h0;
    wr(6'h13, 16'h0007, 2'b00);
    wr(6'h14, 16'h0000, 2'b00);
    irq_req <= 30'h80;
    settle();
    `CHK("masked", 1'b0, irq)
    rd(6'h13, 16'h0001, 2'b00);
    wr(6'h14, 16'h0001, 2'b00);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(6'h13, 16'h0001, 2'b00);
    settle();
    `CHK("cleared", 1'b0, irq)
  endtask : t_events

  task automatic t_wake;
    wr(6'h12, 16'h0020, 2'b00);
    low_power_mode <= 1'b1;
    settle();
    `CHK("wake", 1'b1, clock_restart_req)
    @(posedge aclk);
    low_power_mode <= 1'b0;
    irq_req <= 30'h0;
    wr(6'h01, 16'h0000, 2'b00);
    low_power_mode <= 1'b1;
    wr(6'h01, 16'h0008, 2'b00);
    irq_req <= 30'h80;
    settle();
    `CHK("late", 2'b01, {clock_restart_req, core_irq_valid})
  endtask : t_wake

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_map();
    t_decode();
    t_tie();
    t_fast();
    t_events();
    t_wake();
    final_report();
  end
endmodule : ipcb_bank_bench
